// >>> core/rpps_panel.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module rpps_panel
    import rpps_pkg::*;
#(
    parameter int NPAIR = 4
)(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic mode_key_i,
    input wire logic increment_key_i,
    input wire logic decrement_key_i,
    input wire logic shift_key_i,
    input wire logic recall_key_i,
    input wire logic program_allow_input_i,
    input wire logic preset_trigger_input_i,
    input wire logic sync_strobe_i,
    input wire logic [11:0] angle_i,
    input wire logic [15:0] rpm_i,
    output logic [7:0] mode_o,
    output logic [31:0] disp_value_o,
    output logic [2:0] disp_places_o,
    output logic disp_point_o,
    output logic disp_no_blank_o,
    output logic disp_blink_o,
    output logic chan_blink_o,
    output logic status_led_o,
    output logic [31:0] position_out_o,
    output logic [1:0] chan_out_o,
    output logic motion_o,
    output logic nv_write_o
);

    typedef struct packed {
        rpps_mode_e mode;
        logic [KN-1:0] ks1;
        logic [KN-1:0] ks2;
        logic [KN-1:0] kprev;
        logic dp_edit;
        logic [3:0] dp_sel;
        logic [3:0] dp;
        logic hs_view;
        logic hs_mode;
        logic kb_armed;
        logic [11:0] whole;
        logic [9:0] frac;
        logic [31:0] preset;
        logic [11:0] angle_prev;
        logic [31:0] counts;
        logic [31:0] offset;
        logic [31:0] pos;
        logic [31:0] pos_out;
        logic hs_busy;
        logic [10:0] hs_cnt;
        logic chan_sel;
        logic [3:0] edge_idx;
        logic [1:0] add_stage;
        logic [31:0] edit_val;
        logic [1:0][NPAIR-1:0][1:0][31:0] lim;
        logic [1:0][3:0] cnt;
        logic [1:0] chan_out;
        logic motion;
        logic [15:0] mot_hi;
        logic [15:0] mot_lo;
        logic nv_wr;
        logic dph_valid;
        logic dph_write;
        logic [7:0] dph_addr;
        logic [31:0] disp;
        logic [2:0] disp_places;
        logic disp_point;
        logic disp_arb;
        logic disp_blink;
        logic led;
    } rpps_state_s;

    rpps_state_s q;
    rpps_state_s n;
    logic [KN-1:0] press;
    logic allow;
    logic step_up;
    logic step_dn;
    logic [11:0] dang;
    logic [11:0] whole_new;
    logic [9:0] frac_new;
    logic [3:0] ncnt;
    logic [4:0] nedge;
    logic [31:0] rd;

    // Places after the point for a point code.
    function automatic logic [2:0] dp_places(input logic [3:0] c);
        logic [3:0] p;
        p = (c < DP_REAL_N) ? c : c - DP_REAL_N;
        return p[2:0];
    endfunction

    // Arbitrary codes only move the point; real codes also add resolution digits.
    function automatic logic dp_is_arb(input logic [3:0] c);
        return c >= DP_REAL_N;
    endfunction

    // Whole and fraction combined in thousandths.
    function automatic logic [21:0] scale_milli(input logic [11:0] w, input logic [9:0] f);
        logic [31:0] s;
        s = 32'(w) * MILLI + 32'(f);
        return s[21:0];
    endfunction

    // Counts are revolutions in 1/4096 steps, so real places add true resolution digits.
    function automatic logic [31:0] scale_pos(input logic [31:0] cnt, input logic [21:0] milli,
                                              input logic [3:0] c);
        logic [31:0] mult;
        logic [31:0] mm;
        logic signed [63:0] prod;
        mult = 32'h0000_0001;
        if (!dp_is_arb(c))
        begin
            case (dp_places(c))
                3'h1: mult = 32'h0000_000a;
                3'h2: mult = 32'h0000_0064;
                3'h3: mult = MILLI;
                default: mult = 32'h0000_0001;
            endcase
        end
        mm = 32'(milli) * mult;
        prod = $signed({{32{cnt[31]}}, cnt}) * $signed({32'h0000_0000, mm});
        prod = prod >>> ANGLE_BITS;
        prod = prod / MILLI_S;
        return prod[31:0];
    endfunction

    assign allow = q.ks2[K_ALLOW];
    assign press = q.ks2 & ~q.kprev;
    assign step_up = press[K_INC] & allow;
    assign step_dn = press[K_DEC] & allow;
    assign dang = angle_i - q.angle_prev;
    assign whole_new = step_up ? ((q.whole == WHOLE_MAX) ? q.whole : q.whole + 12'h001)
                               : ((q.whole == 12'h000) ? q.whole : q.whole - 12'h001);
    assign frac_new = step_up ? ((q.frac == FRAC_MAX) ? q.frac : q.frac + 10'h001)
                              : ((q.frac == 10'h000) ? q.frac : q.frac - 10'h001);
    assign ncnt = q.cnt[q.chan_sel];
    assign nedge = {ncnt, 1'b0};

    // Register read mux; the bus never waits and never errors.
    always_comb
    begin
        rd = 32'h0000_0000;
        if (q.dph_addr == REG_STATUS)
        begin
            rd[ST_MODE_LSB +: 8] = q.mode;
            rd[ST_DP_LSB +: 4] = q.dp;
            rd[ST_HS_BIT] = q.hs_mode;
            rd[ST_MOTION_BIT] = q.motion;
            rd[ST_CHAN_LSB +: 2] = q.chan_out;
            rd[ST_ALLOW_BIT] = allow;
        end
        else if (q.dph_addr == REG_POSITION)
            rd = q.pos;
        else if (q.dph_addr == REG_SCALE)
            rd = {6'h00, q.frac, 4'h0, q.whole};
        else if (q.dph_addr == REG_MOT_HI)
            rd = {16'h0000, q.mot_hi};
        else if (q.dph_addr == REG_MOT_LO)
            rd = {16'h0000, q.mot_lo};
    end

    // Next-state logic for the whole panel.
    always_comb
    begin
        n = q;
        n.nv_wr = 1'b0;
        // Pins pass two flops; only the second flop feeds edge detection.
        n.ks1 = {sync_strobe_i, program_allow_input_i, preset_trigger_input_i, recall_key_i,
                 shift_key_i, decrement_key_i, increment_key_i, mode_key_i};
        n.ks2 = q.ks1;
        n.kprev = q.ks2;

        // Track turns from angle steps; wrap through zero is a signed step.
        n.counts = q.counts + {{20{dang[11]}}, dang};
        n.angle_prev = angle_i;

        if (press[K_PRESET])
        begin
            n.counts = 32'h0000_0000;
            n.offset = q.preset;
        end

        // Key handling: the mode key wins over any other key in the same cycle.
        if (press[K_MODE])
        begin
            if (q.dp_edit)
            begin
                n.dp = q.dp_sel;
                n.dp_edit = 1'b0;
                n.nv_wr = 1'b1;
            end
            else if (q.kb_armed || q.hs_view)
            begin
                n.kb_armed = 1'b0;
                n.hs_view = 1'b0;
            end
            else if (q.add_stage == 2'h1)
            begin
                n.lim[q.chan_sel][ncnt[2:0]][0] = q.edit_val;
                n.add_stage = 2'h2;
            end
            else if (q.add_stage == 2'h2)
            begin
                n.lim[q.chan_sel][ncnt[2:0]][1] = q.edit_val;
                n.cnt[q.chan_sel] = ncnt + 4'h1;
                n.add_stage = 2'h0;
                n.nv_wr = 1'b1;
            end
            else
            begin
                n.mode = rpps_mode_e'({q.mode[6:0], q.mode[7]});
                n.edge_idx = 4'h0;
            end
        end
        else
        begin
            case (q.mode)
                M_POS:
                begin
                    if (q.dp_edit && step_up)
                        n.dp_sel = (q.dp_sel == DP_CODES - 4'h1) ? 4'h0 : q.dp_sel + 4'h1;
                    else if (q.dp_edit && step_dn)
                        n.dp_sel = (q.dp_sel == 4'h0) ? DP_CODES - 4'h1 : q.dp_sel - 4'h1;
                    else if (q.hs_view && (step_up || step_dn))
                    begin
                        n.hs_mode = step_up;
                        n.nv_wr = 1'b1;
                    end
                    else if (press[K_SHIFT] && !q.hs_view)
                    begin
                        n.dp_edit = 1'b1;
                        n.dp_sel = q.dp;
                    end
                    else if (press[K_RECALL] && !q.dp_edit)
                        n.hs_view = 1'b1;
                end
                M_SFW:
                begin
                    if ((step_up || step_dn) && whole_new != q.whole &&
                        scale_milli(whole_new, q.frac) >= SCALE_MIN_MILLI)
                    begin
                        n.whole = whole_new;
                        n.counts = 32'h0000_0000;
                        n.offset = 32'h0000_0000;
                        n.nv_wr = 1'b1;
                    end
                end
                M_SFF:
                begin
                    if ((step_up || step_dn) && frac_new != q.frac &&
                        scale_milli(q.whole, frac_new) >= SCALE_MIN_MILLI)
                    begin
                        n.frac = frac_new;
                        n.counts = 32'h0000_0000;
                        n.offset = 32'h0000_0000;
                        n.nv_wr = 1'b1;
                    end
                end
                M_PRE:
                begin
                    if (step_up || step_dn)
                    begin
                        n.preset = step_up ? q.preset + 32'h0000_0001
                                           : q.preset - 32'h0000_0001;
                        n.nv_wr = 1'b1;
                    end
                    else if (press[K_RECALL] && q.kb_armed)
                    begin
                        n.counts = 32'h0000_0000;
                        n.offset = q.preset;
                        n.kb_armed = 1'b0;
                        n.mode = M_POS;
                    end
                    else if (press[K_RECALL])
                        n.kb_armed = 1'b1;
                end
                M_CHN:
                begin
                    if (q.add_stage != 2'h0 && (step_up || step_dn))
                        n.edit_val = step_up ? q.edit_val + 32'h0000_0001
                                             : q.edit_val - 32'h0000_0001;
                    else if ((step_up || step_dn) && {1'b0, q.edge_idx} == nedge &&
                             ncnt < 4'(NPAIR))
                    begin
                        // Editing starts from the null setpoint at the end of the list.
                        n.add_stage = 2'h1;
                        n.edit_val = step_up ? 32'h0000_0001 : 32'hffff_ffff;
                    end
                    else if (press[K_RECALL] && q.add_stage == 2'h0)
                        n.edge_idx = ({1'b0, q.edge_idx} == nedge) ? 4'h0
                                                                   : q.edge_idx + 4'h1;
                    else if (press[K_SHIFT] && q.add_stage == 2'h0)
                    begin
                        n.chan_sel = ~q.chan_sel;
                        n.edge_idx = 4'h0;
                    end
                end
                M_MHI:
                begin
                    if (step_up && q.mot_hi != 16'hffff)
                        n.mot_hi = q.mot_hi + 16'h0001;
                    else if (step_dn && q.mot_hi != q.mot_lo)
                        n.mot_hi = q.mot_hi - 16'h0001;
                end
                M_MLO:
                begin
                    if (step_up && q.mot_lo != q.mot_hi)
                        n.mot_lo = q.mot_lo + 16'h0001;
                    else if (step_dn && q.mot_lo != 16'h0000)
                        n.mot_lo = q.mot_lo - 16'h0001;
                end
                default:
                begin
                    // Speed mode: every key but mode is ignored.
                    n.edit_val = q.edit_val;
                end
            endcase
        end

        // Committed position uses only the confirmed point code.
        n.pos = scale_pos(q.counts, scale_milli(q.whole, q.frac), q.dp) + q.offset;

        // Handshake holds the position output and refreshes it a fixed delay after each sync edge.
        if (!q.hs_mode)
        begin
            n.pos_out = q.pos;
            n.hs_busy = 1'b0;
        end
        else if (q.ks2[K_SYNC] ^ q.kprev[K_SYNC])
        begin
            n.hs_busy = 1'b1;
            n.hs_cnt = 11'h000;
        end
        else if (q.hs_busy && q.hs_cnt == SYNC_DELAY_CYC - 11'h001)
        begin
            n.pos_out = q.pos;
            n.hs_busy = 1'b0;
        end
        else if (q.hs_busy)
            n.hs_cnt = q.hs_cnt + 11'h001;

        // Channel outputs are on inside any stored pair.
        for (int c = 0; c < 2; c++)
        begin
            n.chan_out[c] = 1'b0;
            for (int p = 0; p < NPAIR; p++)
            begin
                if (4'(p) < q.cnt[c] && $signed(q.pos) >= $signed(q.lim[c][p][0]) &&
                    $signed(q.pos) < $signed(q.lim[c][p][1]))
                    n.chan_out[c] = 1'b1;
            end
        end
        n.motion = (rpm_i > q.mot_lo) && (rpm_i < q.mot_hi);

        // Bus: capture the address phase, apply writes in the data phase.
        n.dph_valid = hsel_i && hready_i && htrans_i[1];
        n.dph_write = hwrite_i;
        n.dph_addr = haddr_i[7:0];
        if (q.dph_valid && q.dph_write && q.dph_addr == REG_MOT_HI)
            n.mot_hi = (hwdata_i[15:0] < q.mot_lo) ? q.mot_lo : hwdata_i[15:0];
        else if (q.dph_valid && q.dph_write && q.dph_addr == REG_MOT_LO)
            n.mot_lo = (hwdata_i[15:0] > q.mot_hi) ? q.mot_hi : hwdata_i[15:0];

        // Display image, one cycle behind the state it shows.
        n.disp_places = dp_places(q.dp);
        n.disp_point = q.dp != 4'h0;
        n.disp_arb = dp_is_arb(q.dp);
        n.disp_blink = 1'b0;
        n.led = 1'b0;
        case (q.mode)
            M_POS:
            begin
                if (q.hs_view)
                    n.disp = {31'h0000_0000, q.hs_mode};
                else
                    n.disp = scale_pos(q.counts, scale_milli(q.whole, q.frac),
                                       q.dp_edit ? q.dp_sel : q.dp) + q.offset;
                if (q.dp_edit)
                begin
                    n.disp_places = dp_places(q.dp_sel);
                    n.disp_point = q.dp_sel != 4'h0;
                    n.disp_arb = dp_is_arb(q.dp_sel);
                    n.disp_blink = 1'b1;
                end
            end
            M_RPM: n.disp = {16'h0000, rpm_i};
            M_SFW:
            begin
                n.disp = {20'h0_0000, q.whole};
                n.disp_places = 3'h0;
                n.disp_point = 1'b1;
                n.disp_arb = 1'b0;
            end
            M_SFF:
            begin
                n.disp = {22'h00_0000, q.frac};
                n.disp_places = 3'h3;
                n.disp_point = 1'b1;
                n.disp_arb = 1'b1;
            end
            M_PRE: n.disp = q.preset;
            M_CHN:
            begin
                if (q.add_stage != 2'h0)
                    n.disp = q.edit_val;
                else if ({1'b0, q.edge_idx} < nedge)
                    n.disp = q.lim[q.chan_sel][q.edge_idx[3:1]][q.edge_idx[0]];
                else
                    n.disp = 32'h0000_0000;
                n.led = (q.add_stage == 2'h1) ||
                        (q.add_stage == 2'h0 && {1'b0, q.edge_idx} < nedge && !q.edge_idx[0]);
            end
            M_MHI: n.disp = {16'h0000, q.mot_hi};
            default: n.disp = {16'h0000, q.mot_lo};
        endcase
    end

    // One register for all state; stored setup takes its power-up defaults here.
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
            q.mode <= M_POS;
            q.whole <= RST_WHOLE;
            q.frac <= RST_FRAC;
            q.dp <= RST_DP;
            q.mot_hi <= RST_MOT_HI;
            q.mot_lo <= RST_MOT_LO;
        end
        else
            q <= n;
    end

    assign hrdata_o = rd;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign mode_o = q.mode;
    assign disp_value_o = q.disp;
    assign disp_places_o = q.disp_places;
    assign disp_point_o = q.disp_point;
    assign disp_no_blank_o = q.disp_arb;
    assign disp_blink_o = q.disp_blink;
    assign chan_blink_o = q.add_stage != 2'h0;
    assign status_led_o = q.led;
    assign position_out_o = q.pos_out;
    assign chan_out_o = q.chan_out;
    assign motion_o = q.motion;
    assign nv_write_o = q.nv_wr;

endmodule

`default_nettype wire

// >>> include/rpps_pkg.sv
`default_nettype none
package rpps_pkg;

    // Key and pin input vector, one bit per synchronised pin.
    localparam int KN = 8;
    localparam int K_MODE = 0;
    localparam int K_INC = 1;
    localparam int K_DEC = 2;
    localparam int K_SHIFT = 3;
    localparam int K_RECALL = 4;
    localparam int K_PRESET = 5;
    localparam int K_ALLOW = 6;
    localparam int K_SYNC = 7;

    // The eight display and programming modes, in the order the mode key walks them.
    typedef enum logic [7:0] {
        M_POS = 8'h01,
        M_RPM = 8'h02,
        M_SFW = 8'h04,
        M_SFF = 8'h08,
        M_PRE = 8'h10,
        M_CHN = 8'h20,
        M_MHI = 8'h40,
        M_MLO = 8'h80
    } rpps_mode_e;

    // Angle resolution and scale factor limits.
    localparam int ANGLE_BITS = 12;
    localparam logic [11:0] WHOLE_MAX = 12'hfff;
    localparam logic [9:0] FRAC_MAX = 10'h3e7;
    localparam logic [21:0] SCALE_MIN_MILLI = 22'h00_012c;
    localparam logic [31:0] MILLI = 32'h0000_03e8;
    localparam logic signed [63:0] MILLI_S = 64'sh0000_0000_0000_03e8;

    // Decimal point codes: 0..3 real places, then 4..8 arbitrary places 0..4.
    localparam logic [3:0] DP_REAL_N = 4'h4;
    localparam logic [3:0] DP_ARB_N = 4'h5;
    localparam logic [3:0] DP_CODES = 4'h9;

    // Handshake refresh delay after a sync edge.
    localparam int CLK_PERIOD_NS = 5;
    localparam int SYNC_DELAY_NS = 5000;
    localparam int SYNC_DELAY_MAX_NS = 150000;
    localparam int SYNC_DELAY_CYC_INT = (SYNC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] SYNC_DELAY_CYC = 11'(SYNC_DELAY_CYC_INT);

    // Reset values of the stored setup.
    localparam logic [11:0] RST_WHOLE = 12'h001;
    localparam logic [9:0] RST_FRAC = 10'h000;
    localparam logic [3:0] RST_DP = 4'h0;
    localparam logic [15:0] RST_MOT_HI = 16'hffff;
    localparam logic [15:0] RST_MOT_LO = 16'h0000;

    // Register byte offsets and field positions.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_POSITION = 8'h04;
    localparam logic [7:0] REG_SCALE = 8'h08;
    localparam logic [7:0] REG_MOT_HI = 8'h0c;
    localparam logic [7:0] REG_MOT_LO = 8'h10;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_DP_LSB = 8;
    localparam int ST_HS_BIT = 12;
    localparam int ST_MOTION_BIT = 13;
    localparam int ST_CHAN_LSB = 14;
    localparam int ST_ALLOW_BIT = 16;
    localparam int SC_FRAC_LSB = 16;

endpackage
`default_nettype wire

// >>> tb/rpps_keypad_model.sv
`timescale 1ns/10ps
`default_nettype none
// Operator keypad and preset pin, as seen at the panel's synchronised inputs.
module rpps_keypad_model
    import rpps_pkg::*;
(
    input wire logic clk_i,
    output logic [KN-1:0] pins_o
);
    initial pins_o = '0;
    // A press is held four cycles, then released eight, so the edge detector re-arms.
    task press(input int k);
        @(posedge clk_i);
        pins_o[k] <= 1'b1;
        repeat (4) @(posedge clk_i);
        pins_o[k] <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    // Level pins such as the program allow switch.
    task level(input int k, input logic v);
        @(posedge clk_i);
        pins_o[k] <= v;
    endtask
endmodule
`default_nettype wire

// >>> tb/rpps_panel_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Mode walking, store pulses and bus answers of the panel.
module rpps_panel_sva (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] mode_o,
    input wire logic nv_write_o,
    input wire logic disp_blink_o,
    input wire logic chan_blink_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Exactly one mode is active, and a change is one step on or back home.
    chk_mode_onehot: assert property ($onehot(mode_o))
        else $error("mode not one-hot");
    chk_mode_step: assert property ($changed(mode_o) |->
        mode_o == {$past(mode_o[6:0]), $past(mode_o[7])} || mode_o == 8'h01)
        else $error("mode skipped a step");
    // Reset is checked during reset itself, so it is not disabled by it.
    chk_reset_home: assert property (disable iff (1'b0) !rst_b_i |=> mode_o == 8'h01)
        else $error("reset did not enter position mode");
    chk_rpm_quiet: assert property (mode_o == 8'h02 |-> !nv_write_o)
        else $error("store while in speed mode");
    chk_store_pulse: assert property (nv_write_o |=> !nv_write_o)
        else $error("store pulse longer than one cycle");
    chk_point_blink: assert property (disp_blink_o |-> mode_o == 8'h01)
        else $error("point blinks outside position mode");
    chk_chan_blink: assert property (chan_blink_o |-> mode_o == 8'h20)
        else $error("channel blinks outside channel mode");
    chk_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready and okay");
endmodule
`default_nettype wire

// >>> tb/rpps_panel_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rpps_panel_bench
    import rpps_pkg::*;
;
    logic clk, rst_b, hsel, hwrite, hready, hresp, point, blink, no_blank, motion, led;
    logic [1:0] htrans, chan;
    logic [2:0] places;
    logic [31:0] haddr, hwdata, hrdata, rd, value, pos_out;
    logic [11:0] angle;
    logic [15:0] rpm;
    logic [7:0] mode, exp_mode;
    logic [KN-1:0] pins;
    int mismatches, checks_done;
    rpps_keypad_model kp (.clk_i(clk), .pins_o(pins));
    rpps_panel #(.NPAIR(4)) dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .mode_key_i(pins[K_MODE]), .increment_key_i(pins[K_INC]),
        .decrement_key_i(pins[K_DEC]), .shift_key_i(pins[K_SHIFT]),
        .recall_key_i(pins[K_RECALL]), .program_allow_input_i(pins[K_ALLOW]),
        .preset_trigger_input_i(pins[K_PRESET]), .sync_strobe_i(pins[K_SYNC]),
        .angle_i(angle), .rpm_i(rpm), .mode_o(mode), .disp_value_o(value),
        .disp_places_o(places), .disp_point_o(point), .disp_no_blank_o(no_blank),
        .disp_blink_o(blink), .chan_blink_o(), .status_led_o(led), .position_out_o(pos_out),
        .chan_out_o(chan), .motion_o(motion), .nv_write_o());
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single-word transfer; the read data is taken at the data phase's closing edge.
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask
    task step_mode();
        kp.press(K_MODE);
        exp_mode = {exp_mode[6:0], exp_mode[7]};
        check("mode", 32'(mode), 32'(exp_mode));
    endtask
    // The motion output lags the speed input, so it is given a bounded time to settle.
    task settle(input logic exp);
        for (int n = 0; n < 20 && motion !== exp; n++) @(posedge clk);
        check("motion", 32'(motion), 32'(exp));
    endtask
    // Eight quarter-turn steps make two revolutions.
    task turn2();
        for (int i = 1; i <= 8; i++)
        begin
            @(posedge clk);
            angle <= 12'(i * 1024);
        end
        repeat (4) @(posedge clk);
    endtask
    task summarize();
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        {rst_b, hwrite, htrans, haddr, hwdata, angle, rpm} = '0;
        hsel = 1'b1;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("mode", 32'(mode), 32'h0000_0001);
        bus(1'b1, 8'h20, 32'h0000_0007);
        bus(1'b1, REG_SCALE, 32'h0000_0bad);
        rdchk("scale", REG_SCALE, 32'h0000_0001);
        rdchk("mot_hi", REG_MOT_HI, 32'h0000_ffff);
        turn2();
        rdchk("position", REG_POSITION, 32'h0000_0002);
        exp_mode = 8'h01;
        rpm <= 16'h1234;
        kp.level(K_ALLOW, 1'b1);
        step_mode();
        check("rpm", value, 32'h0000_1234);
        kp.press(K_INC);
        step_mode();
        check("whole point", {29'h0, places}, 32'h0000_0000);
        check("whole lit", 32'(point), 32'h0000_0001);
        kp.level(K_ALLOW, 1'b0);
        kp.press(K_INC);
        rdchk("scale", REG_SCALE, 32'h0000_0001);
        kp.level(K_ALLOW, 1'b1);
        kp.press(K_DEC);
        rdchk("scale", REG_SCALE, 32'h0000_0001);
        kp.press(K_INC);
        rdchk("scale", REG_SCALE, 32'h0000_0002);
        rdchk("position", REG_POSITION, 32'h0000_0000);
        step_mode();
        check("frac point", {29'h0, places}, 32'h0000_0003);
        step_mode();
        kp.press(K_INC);
        rdchk("position", REG_POSITION, 32'h0000_0000);
        kp.press(K_RECALL);
        kp.press(K_RECALL);
        exp_mode = 8'h01;
        check("mode", 32'(mode), 32'h0000_0001);
        rdchk("position", REG_POSITION, 32'h0000_0001);
        for (int i = 0; i < 8; i++) step_mode();
        rdchk("scale", REG_SCALE, 32'h0000_0002);
        kp.press(K_SHIFT);
        check("blink", 32'(blink), 32'h0000_0001);
        for (int i = 0; i < 4; i++) kp.press(K_INC);
        check("no_blank", 32'(no_blank), 32'h0000_0001);
        kp.press(K_MODE);
        check("blink", 32'(blink), 32'h0000_0000);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        check("point", 32'(rd[11:8]), 32'h0000_0004);
        bus(1'b1, REG_MOT_LO, 32'h0000_0005);
        rdchk("mot_lo", REG_MOT_LO, 32'h0000_0005);
        rpm <= 16'h0064;
        settle(1'b1);
        bus(1'b1, REG_MOT_HI, 32'h0000_0064);
        settle(1'b0);
        rpm <= 16'h0006;
        settle(1'b1);
        rpm <= 16'h0005;
        settle(1'b0);
        turn2();
        rdchk("position", REG_POSITION, 32'h0000_0005);
        kp.press(K_PRESET);
        rdchk("position", REG_POSITION, 32'h0000_0001);
        check("pos_out", pos_out, 32'h0000_0001);
        kp.press(K_RECALL);
        check("hs", value, 32'h0000_0000);
        kp.press(K_INC);
        check("hs", value, 32'h0000_0001);
        kp.press(K_MODE);
        turn2();
        kp.press(K_SYNC);
        repeat (990) @(posedge clk);
        check("pos_out", pos_out, 32'h0000_0001);
        repeat (10) @(posedge clk);
        check("pos_out", pos_out, 32'h0000_0005);
        for (int i = 0; i < 5; i++) step_mode();
        check("null", value, 32'h0000_0000);
        kp.press(K_INC);
        check("led", 32'(led), 32'h0000_0001);
        kp.press(K_MODE);
        for (int i = 0; i < 5; i++) kp.press(K_INC);
        kp.press(K_MODE);
        check("chan", 32'(chan), 32'h0000_0001);
        kp.press(K_RECALL);
        check("edge", value, 32'h0000_0006);
        check("led", 32'(led), 32'h0000_0000);
        summarize();
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
bind rpps_panel rpps_panel_sva chk_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .mode_o(mode_o), .nv_write_o(nv_write_o), .disp_blink_o(disp_blink_o),
    .chan_blink_o(chan_blink_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
`default_nettype wire
